// File: design/prspc_pkg.sv
package prspc_pkg;

  // Pin array geometry
  localparam int PORT_WIDTH = 32; // Pins per port
  localparam int PORT_COUNT = 3; // Ports handled by this block
  localparam int PORT0_BASE = 0; // Flat index of port 0 bit 0
  localparam int PORT1_BASE = 32; // Flat index of port 1 bit 0

  // Flat pin indices of named pins used by the logic or the checks
  localparam int PIN_BOOT_SELECT_0 = PORT0_BASE + 0; // Boot select input 0
  localparam int PIN_GENERAL_SAMPLE = PORT0_BASE + 1; // Ordinary pin watched by checks
  localparam int PIN_SERIAL_MEM_SELECT_0 = PORT0_BASE + 4;
  localparam int PIN_SERIAL_MEM_CLOCK = PORT0_BASE + 5;
  localparam int PIN_SERIAL_MEM_DATA_IN = PORT0_BASE + 6;
  localparam int PIN_SERIAL_MEM_DATA_OUT = PORT0_BASE + 7;
  localparam int PIN_SERIAL_MEM_SELECT_3 = PORT0_BASE + 10;
  localparam int PIN_BOOT_SELECT_1 = PORT0_BASE + 11; // Shared with select 2
  localparam int PIN_SERIAL_MEM_SELECT_1 = PORT0_BASE + 12;
  localparam int PIN_RETURNED_TEST_CLOCK = PORT0_BASE + 13;
  localparam int PIN_TEST_CLOCK_IN = PORT1_BASE + 16;
  localparam int PIN_TEST_MODE_SELECT = PORT1_BASE + 17;
  localparam int PIN_TEST_DATA_IN = PORT1_BASE + 18;
  localparam int PIN_TEST_DATA_OUT = PORT1_BASE + 19;

  // Returned clock resynchroniser depth, output flop included
  localparam int SYNC_STAGES = 3;

  // Boot select code {pin 11, pin 0} that means serial flash
  localparam logic [1:0] BOOT_SERIAL_FLASH = 2'h1;

  // Per-pin electrical mode
  typedef enum logic [2:0]
  {
    PIN_IN_FLOAT = 3'b000,
    PIN_IN_PULL_UP = 3'b001,
    PIN_IN_PULL_DOWN = 3'b010,
    PIN_OUT_PUSH_PULL = 3'b011,
    PIN_OUT_OPEN_DRAIN = 3'b100
  } prspc_pin_mode_type;

  // Software pin configuration word
  typedef struct packed {
    logic alt; // Route alternate function data instead of port data
    prspc_pin_mode_type mode;
  } prspc_pin_cfg_type;

  // Same reset word for every pin, debug pins included
  localparam prspc_pin_cfg_type CFG_RESET = '{alt: 1'b0, mode: PIN_IN_FLOAT};

  // Pad control bundle; oe_n low while the pad is driven
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
  } prspc_pad_type;

  // Pad state while nothing drives or pulls
  localparam prspc_pad_type PAD_FLOAT = '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};

  // Debug port output side
  typedef struct packed {
    logic data_out; // Serial test data
    logic active; // Test data is being shifted out
  } prspc_debug_type;

  // Serial memory interface output side
  typedef struct packed {
    logic data_out;
    logic clock;
    logic select_0;
  } prspc_serial_mem_type;

  // Boot sampling sequence
  typedef enum logic [1:0]
  {
    BOOT_HOLD = 2'b00,
    BOOT_SAMPLE = 2'b01,
    BOOT_RUN = 2'b10
  } prspc_boot_state_type;

endpackage : prspc_pkg

// File: design/prspc_pin_config.sv
`timescale 1ns/10ps
module prspc_pin_config #(
  parameter int PORT_COUNT = prspc_pkg::PORT_COUNT,
  parameter int PORT_WIDTH = prspc_pkg::PORT_WIDTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [PORT_COUNT*PORT_WIDTH-1:0] pad_in,
  input wire logic [PORT_COUNT*PORT_WIDTH-1:0] gpio_out,
  input wire logic [PORT_COUNT*PORT_WIDTH-1:0] alt_out,
  input wire logic cfg_wr,
  input wire logic [$clog2(PORT_COUNT*PORT_WIDTH)-1:0] cfg_pin,
  input wire prspc_pkg::prspc_pin_cfg_type cfg_data,
  input wire prspc_pkg::prspc_debug_type debug_out,
  input wire prspc_pkg::prspc_serial_mem_type serial_mem_out,
  output prspc_pkg::prspc_pad_type [PORT_COUNT*PORT_WIDTH-1:0] pad_ctrl,
  output logic [PORT_COUNT*PORT_WIDTH-1:0] gpio_in,
  output logic test_clock_in,
  output logic test_mode_select,
  output logic test_data_in,
  output logic serial_mem_data_in,
  output logic [1:0] boot_mode,
  output logic code_fetch_enable,
  output logic serial_mem_boot_active
);

  localparam int NUM_PINS = PORT_COUNT * PORT_WIDTH; // Flat pin count
  localparam int PIN_W = $clog2(NUM_PINS); // Pin index width

  // Whole block state in one word
  typedef struct packed {
    prspc_pkg::prspc_pin_cfg_type [NUM_PINS-1:0] cfg; // Software pin configuration
    logic [NUM_PINS-1:0] sm_override; // Serial flash boot override per pin
    logic [prspc_pkg::SYNC_STAGES-2:0] clk_sync; // First resync stages
    prspc_pkg::prspc_boot_state_type boot; // Boot sampling sequence
    logic [1:0] boot_mode; // Latched boot select pins
    logic fetch_enable; // Processor may fetch
    prspc_pkg::prspc_pad_type [NUM_PINS-1:0] pad; // Registered pad controls
    logic [NUM_PINS-1:0] pin_in; // Registered pad inputs
    logic test_clock; // Registered debug inputs
    logic test_mode;
    logic test_data;
    logic sm_data_in;
    logic sm_active; // Any boot override still in force
  } prspc_state_type;

  prspc_state_type state; // Current state
  prspc_state_type next_state; // Value for the next edge

  // Pad controls from a mode word and the data to send
  function automatic prspc_pkg::prspc_pad_type pad_from_cfg(
    input prspc_pkg::prspc_pin_cfg_type cfg,
    input logic data
  );
    prspc_pkg::prspc_pad_type pad;
    pad = prspc_pkg::PAD_FLOAT;
    case (cfg.mode)
      prspc_pkg::PIN_IN_PULL_UP:
      begin
        pad.pull_up = 1'b1;
      end
      prspc_pkg::PIN_IN_PULL_DOWN:
      begin
        pad.pull_down = 1'b1;
      end
      prspc_pkg::PIN_OUT_PUSH_PULL:
      begin
        pad.out = data;
        pad.oe_n = 1'b0;
      end
      prspc_pkg::PIN_OUT_OPEN_DRAIN:
      begin
        pad.oe_n = data;
      end
      default:
      begin
        pad = prspc_pkg::PAD_FLOAT; // Floating input
      end
    endcase
    return pad;
  endfunction : pad_from_cfg

  // Push-pull alternate drive, shared by overrides
  localparam prspc_pkg::prspc_pin_cfg_type CFG_ALT_PP = '{alt: 1'b1, mode: prspc_pkg::PIN_OUT_PUSH_PULL};
  // Next-state logic
  always_comb
  begin
    next_state = state;
    next_state.pin_in = pad_in;
    // Resync chain; the first stage feeds only the second
    next_state.clk_sync = {state.clk_sync[prspc_pkg::SYNC_STAGES-3:0], pad_in[prspc_pkg::PIN_TEST_CLOCK_IN]};
    next_state.test_clock = state.pin_in[prspc_pkg::PIN_TEST_CLOCK_IN];
    next_state.test_mode = state.pin_in[prspc_pkg::PIN_TEST_MODE_SELECT];
    next_state.test_data = state.pin_in[prspc_pkg::PIN_TEST_DATA_IN];
    next_state.sm_data_in = state.pin_in[prspc_pkg::PIN_SERIAL_MEM_DATA_IN];

    // Software write; stored even for debug pins but ignored there
    if (cfg_wr)
    begin
      next_state.cfg[cfg_pin] = cfg_data;
      next_state.sm_override[cfg_pin] = 1'b0;
    end

    // Boot pins sampled one cycle after reset release
    case (state.boot)
      prspc_pkg::BOOT_HOLD:
      begin
        next_state.boot = prspc_pkg::BOOT_SAMPLE;
      end
      prspc_pkg::BOOT_SAMPLE:
      begin
        next_state.boot_mode = {pad_in[prspc_pkg::PIN_BOOT_SELECT_1], pad_in[prspc_pkg::PIN_BOOT_SELECT_0]};
        next_state.fetch_enable = 1'b1;
        next_state.boot = prspc_pkg::BOOT_RUN;
        // Only the data out, clock, select-0 and data in pins take the override
        if ({pad_in[prspc_pkg::PIN_BOOT_SELECT_1], pad_in[prspc_pkg::PIN_BOOT_SELECT_0]}
            == prspc_pkg::BOOT_SERIAL_FLASH)
        begin
          next_state.sm_override[prspc_pkg::PIN_SERIAL_MEM_DATA_OUT] = 1'b1;
          next_state.sm_override[prspc_pkg::PIN_SERIAL_MEM_CLOCK] = 1'b1;
          next_state.sm_override[prspc_pkg::PIN_SERIAL_MEM_SELECT_0] = 1'b1;
          next_state.sm_override[prspc_pkg::PIN_SERIAL_MEM_DATA_IN] = 1'b1;
        end
      end
      prspc_pkg::BOOT_RUN:
      begin
        next_state.boot = prspc_pkg::BOOT_RUN; // Stays until reset
      end
      default:
      begin
        next_state.boot = prspc_pkg::BOOT_HOLD; // Illegal code recovers
      end
    endcase
    next_state.sm_active = |next_state.sm_override;

    // Per-pin pad control from configuration
    for (int i = 0; i < NUM_PINS; i++)
    begin
      next_state.pad[i] = pad_from_cfg(state.cfg[i], state.cfg[i].alt ? alt_out[i] : gpio_out[i]);
    end

    // Serial flash boot override, until software reprograms the pin
    if (state.sm_override[prspc_pkg::PIN_SERIAL_MEM_DATA_OUT])
    begin
      next_state.pad[prspc_pkg::PIN_SERIAL_MEM_DATA_OUT] = pad_from_cfg(CFG_ALT_PP, serial_mem_out.data_out);
    end
    if (state.sm_override[prspc_pkg::PIN_SERIAL_MEM_CLOCK])
    begin
      next_state.pad[prspc_pkg::PIN_SERIAL_MEM_CLOCK] = pad_from_cfg(CFG_ALT_PP, serial_mem_out.clock);
    end
    if (state.sm_override[prspc_pkg::PIN_SERIAL_MEM_SELECT_0])
    begin
      next_state.pad[prspc_pkg::PIN_SERIAL_MEM_SELECT_0] = pad_from_cfg(CFG_ALT_PP, serial_mem_out.select_0);
    end
    if (state.sm_override[prspc_pkg::PIN_SERIAL_MEM_DATA_IN])
    begin
      next_state.pad[prspc_pkg::PIN_SERIAL_MEM_DATA_IN] = prspc_pkg::PAD_FLOAT;
    end

    // Debug pins: fixed functions whatever the config words say
    next_state.pad[prspc_pkg::PIN_TEST_CLOCK_IN] = prspc_pkg::PAD_FLOAT;
    next_state.pad[prspc_pkg::PIN_TEST_MODE_SELECT] = prspc_pkg::PAD_FLOAT;
    next_state.pad[prspc_pkg::PIN_TEST_DATA_IN] = prspc_pkg::PAD_FLOAT;
    next_state.pad[prspc_pkg::PIN_TEST_DATA_OUT] = prspc_pkg::PAD_FLOAT;
    if (debug_out.active)
    begin
      next_state.pad[prspc_pkg::PIN_TEST_DATA_OUT] = pad_from_cfg(CFG_ALT_PP, debug_out.data_out);
    end
    // Third resync stage is the pad flop itself
    next_state.pad[prspc_pkg::PIN_RETURNED_TEST_CLOCK] =
      pad_from_cfg(CFG_ALT_PP, state.clk_sync[prspc_pkg::SYNC_STAGES-2]);
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
      for (int i = 0; i < NUM_PINS; i++)
      begin
        state.cfg[i] <= prspc_pkg::CFG_RESET;
        state.pad[i] <= prspc_pkg::PAD_FLOAT;
      end
      state.boot <= prspc_pkg::BOOT_HOLD;
      // Returned clock drives low through reset
      state.pad[prspc_pkg::PIN_RETURNED_TEST_CLOCK].oe_n <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign pad_ctrl = state.pad;
  assign gpio_in = state.pin_in;
  assign test_clock_in = state.test_clock;
  assign test_mode_select = state.test_mode;
  assign test_data_in = state.test_data;
  assign serial_mem_data_in = state.sm_data_in;
  assign boot_mode = state.boot_mode;
  assign code_fetch_enable = state.fetch_enable;
  assign serial_mem_boot_active = state.sm_active;
  // Checks
  sequence s_boot_sample;
    clk_en && state.boot == prspc_pkg::BOOT_SAMPLE;
  endsequence
  sequence s_boot_done;
    code_fetch_enable
      && boot_mode == $past({pad_in[prspc_pkg::PIN_BOOT_SELECT_1], pad_in[prspc_pkg::PIN_BOOT_SELECT_0]});
  endsequence
  property p_general_float;
    @(posedge clk_sys) disable iff (reset)
    clk_en && state.cfg[prspc_pkg::PIN_GENERAL_SAMPLE] == prspc_pkg::CFG_RESET
    |=> pad_ctrl[prspc_pkg::PIN_GENERAL_SAMPLE] == prspc_pkg::PAD_FLOAT;
  endproperty
  a_general_float: assert property (p_general_float) else $error("Reset-config pin not floating");
  property p_debug_inputs_float;
    @(posedge clk_sys) disable iff (reset)
    clk_en |=> pad_ctrl[prspc_pkg::PIN_TEST_MODE_SELECT] == prspc_pkg::PAD_FLOAT
      && pad_ctrl[prspc_pkg::PIN_TEST_DATA_IN] == prspc_pkg::PAD_FLOAT;
  endproperty
  a_debug_inputs_float: assert property (p_debug_inputs_float) else $error("Debug input pin not floating");
  property p_data_out_idle;
    @(posedge clk_sys) disable iff (reset)
    clk_en && !debug_out.active && cfg_wr && cfg_pin == PIN_W'(prspc_pkg::PIN_TEST_DATA_OUT)
    |=> pad_ctrl[prspc_pkg::PIN_TEST_DATA_OUT].oe_n ##1 !state.cfg[prspc_pkg::PIN_TEST_DATA_OUT].alt
      || pad_ctrl[prspc_pkg::PIN_TEST_DATA_OUT].oe_n || !clk_en || debug_out.active || $past(debug_out.active);
  endproperty
  a_data_out_idle: assert property (p_data_out_idle) else $error("Test data out driven while idle");
  property p_data_out_shift;
    @(posedge clk_sys) disable iff (reset)
    clk_en && debug_out.active
    |=> !pad_ctrl[prspc_pkg::PIN_TEST_DATA_OUT].oe_n
      && pad_ctrl[prspc_pkg::PIN_TEST_DATA_OUT].out == $past(debug_out.data_out);
  endproperty
  a_data_out_shift: assert property (p_data_out_shift) else $error("Test data out not driven");
  property p_returned_clock;
    @(posedge clk_sys) disable iff (reset)
    clk_en [*3] |=> !pad_ctrl[prspc_pkg::PIN_RETURNED_TEST_CLOCK].oe_n
      && pad_ctrl[prspc_pkg::PIN_RETURNED_TEST_CLOCK].out == $past(pad_in[prspc_pkg::PIN_TEST_CLOCK_IN], 3);
  endproperty
  a_returned_clock: assert property (p_returned_clock) else $error("Returned clock not three-stage copy");
  property p_boot_sample;
    @(posedge clk_sys) disable iff (reset)
    s_boot_sample |=> s_boot_done;
  endproperty
  a_boot_sample: assert property (p_boot_sample) else $error("Boot pins not latched before fetch");
  property p_serial_clock;
    @(posedge clk_sys) disable iff (reset)
    clk_en && state.sm_override[prspc_pkg::PIN_SERIAL_MEM_CLOCK]
    |=> !pad_ctrl[prspc_pkg::PIN_SERIAL_MEM_CLOCK].oe_n
      && pad_ctrl[prspc_pkg::PIN_SERIAL_MEM_CLOCK].out == $past(serial_mem_out.clock);
  endproperty
  a_serial_clock: assert property (p_serial_clock) else $error("Serial memory clock not enabled");
  property p_selects_untouched;
    @(posedge clk_sys) disable iff (reset)
    code_fetch_enable |-> !state.sm_override[prspc_pkg::PIN_SERIAL_MEM_SELECT_1]
      && !state.sm_override[prspc_pkg::PIN_BOOT_SELECT_1] && !state.sm_override[prspc_pkg::PIN_SERIAL_MEM_SELECT_3];
  endproperty
  a_selects_untouched: assert property (p_selects_untouched) else $error("Serial selects 1-3 overridden");
  property p_pull_up;
    @(posedge clk_sys) disable iff (reset)
    clk_en && state.cfg[prspc_pkg::PIN_GENERAL_SAMPLE].mode == prspc_pkg::PIN_IN_PULL_UP
    |=> pad_ctrl[prspc_pkg::PIN_GENERAL_SAMPLE].pull_up && pad_ctrl[prspc_pkg::PIN_GENERAL_SAMPLE].oe_n;
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("Pull-up not applied");
  property p_open_drain;
    @(posedge clk_sys) disable iff (reset)
    clk_en && state.cfg[prspc_pkg::PIN_GENERAL_SAMPLE].mode == prspc_pkg::PIN_OUT_OPEN_DRAIN
      && !state.cfg[prspc_pkg::PIN_GENERAL_SAMPLE].alt
    |=> pad_ctrl[prspc_pkg::PIN_GENERAL_SAMPLE].oe_n == $past(gpio_out[prspc_pkg::PIN_GENERAL_SAMPLE])
      && !pad_ctrl[prspc_pkg::PIN_GENERAL_SAMPLE].out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain drive wrong");
  property p_override_release;
    @(posedge clk_sys) disable iff (reset)
    clk_en && cfg_wr && cfg_pin == PIN_W'(prspc_pkg::PIN_SERIAL_MEM_CLOCK) && state.boot == prspc_pkg::BOOT_RUN
    |=> !state.sm_override[prspc_pkg::PIN_SERIAL_MEM_CLOCK];
  endproperty
  a_override_release: assert property (p_override_release) else $error("Override kept after reprogram");
endmodule : prspc_pin_config

// File: verification/prspc_probe_model.sv
`timescale 1ns/10ps
// Far side: debug probe on the test pins and boot flash on data in
module prspc_probe_model (
  input wire logic clk_sys,
  input wire logic frame,
  input wire logic select_0,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic flash_q
);
  logic [1:0] div = 2'h0; // Probe clock divider
  logic tck_q = 1'b0; // Probe clock level
  logic tms_q = 1'b0; // Mode select level
  logic tdi_q = 1'b0; // Data in level
  logic fl_q = 1'b0; // Flash data level
  assign tck = tck_q;
  assign tms = tms_q;
  assign tdi = tdi_q;
  assign flash_q = fl_q;
  // Probe clock runs only inside a frame and rests low between frames
  always @(negedge clk_sys)
  begin
    if (frame)
    begin
      div <= div + 2'h1;
      tck_q <= (div == 2'h3) ? tck_q : ~tck_q;
      tms_q <= div[0];
      tdi_q <= div[1];
    end
    else
    begin
      // Released lines toggle so a stale value is never mistaken for data
      div <= 2'h0;
      tck_q <= 1'b0;
      tms_q <= ~tms_q;
      tdi_q <= ~tdi_q;
    end
    // Flash toggles while selected; otherwise it drives div[0] xor the probe clock level
    fl_q <= select_0 ? ~fl_q : (div[0] ^ tck_q);
  end
endmodule : prspc_probe_model

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [95:0] pad_drv = '0; // Bench pad levels
  logic [95:0] pad_in;
  logic [95:0] gpio_out = '0;
  logic [95:0] alt_out = '0;
  logic cfg_wr = 1'b0;
  logic [6:0] cfg_pin = '0;
  prspc_pkg::prspc_pin_cfg_type cfg_data = prspc_pkg::CFG_RESET;
  prspc_pkg::prspc_debug_type debug_out = '0;
  prspc_pkg::prspc_serial_mem_type serial_mem_out = '0;
  prspc_pkg::prspc_pad_type [95:0] pad_ctrl;
  logic [1:0] boot_mode;
  logic code_fetch_enable;
  logic serial_mem_boot_active;
  logic [95:0] gpio_in;
  logic test_clock_in;
  logic test_mode_select;
  logic test_data_in;
  logic serial_mem_data_in;
  logic clk_en = 1'b1; // Freeze control
  logic frame = 1'b0; // Probe activity window
  logic tck;
  logic tms;
  logic tdi;
  logic flash_q;
  logic [2:0] tck_hist = '0; // Test clock at the last edges
  logic [3:0] pin_h1 = '0; // Pads 51..48 one edge back
  logic [3:0] dbg_h1 = '0; // Flash and probe inputs one edge back
  logic [3:0] dbg_h2 = '0; // Same, two edges back
  int err_total = 0;
  int tests_run = 0;
  int i;
  // 100 ns clock
  always #50 clk_sys = ~clk_sys;
  // Partner drives the debug inputs and flash data in
  always_comb
  begin
    pad_in = pad_drv;
    pad_in[48] = tck;
    pad_in[49] = tms;
    pad_in[50] = tdi;
    pad_in[6] = flash_q;
  end
  // History for the resync and input pipeline checks
  always @(posedge clk_sys)
  begin
    tck_hist <= {tck_hist[1:0], pad_in[48]};
    pin_h1 <= pad_in[51:48];
    dbg_h1 <= {pad_in[6], pad_in[50], pad_in[49], pad_in[48]};
    dbg_h2 <= dbg_h1;
  end
  prspc_pin_config uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .pad_in(pad_in),
    .gpio_out(gpio_out), .alt_out(alt_out), .cfg_wr(cfg_wr), .cfg_pin(cfg_pin), .cfg_data(cfg_data),
    .debug_out(debug_out), .serial_mem_out(serial_mem_out), .pad_ctrl(pad_ctrl), .gpio_in(gpio_in),
    .test_clock_in(test_clock_in), .test_mode_select(test_mode_select), .test_data_in(test_data_in),
    .serial_mem_data_in(serial_mem_data_in),
    .boot_mode(boot_mode), .code_fetch_enable(code_fetch_enable),
    .serial_mem_boot_active(serial_mem_boot_active));
  prspc_probe_model probe (.clk_sys(clk_sys), .frame(frame), .select_0(pad_ctrl[4].out),
    .tck(tck), .tms(tms), .tdi(tdi), .flash_q(flash_q));
  // Report and end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // Compare one value
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // Compare a pad word {out, oe_n, pull_up, pull_down}
  task automatic pad(input int pin, input logic [3:0] exp);
    chk($sformatf("pad_ctrl[%0d]", pin), exp, pad_ctrl[pin]);
  endtask : pad
  // One config write, returns once the pad shows it
  task automatic wr(input int pin, input prspc_pkg::prspc_pin_cfg_type cfg);
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_pin = pin[6:0];
    cfg_data = cfg;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr
  // Reset with boot pins set, then wait for the boot sample
  task automatic do_reset(input logic [1:0] boot);
    reset = 1'b1;
    pad_drv[11] = boot[1];
    pad_drv[0] = boot[0];
    repeat (2) @(negedge clk_sys);
    pad(13, 4'h0);
    pad(1, 4'h4);
    pad(7, 4'h4);
    pad(51, 4'h4);
    reset = 1'b0;
    for (i = 0; i < 8 && code_fetch_enable !== 1'b1; i++) @(negedge clk_sys);
    if (code_fetch_enable !== 1'b1)
    begin
      $display("MISMATCH code_fetch_enable expected 1 seen %b", code_fetch_enable);
      err_total++;
      give_verdict();
    end
    chk("boot_mode", {2'h0, boot}, {2'h0, boot_mode});
  endtask : do_reset
  initial
  begin
    do_reset(2'b01);
    // Serial flash boot: memory output pins driven, data in floating, other selects untouched
    serial_mem_out = 3'b101;
    @(negedge clk_sys);
    pad(7, 4'h8);
    pad(5, 4'h0);
    pad(4, 4'h8);
    pad(6, 4'h4);
    chk("boot_active", 4'h1, {3'h0, serial_mem_boot_active});
    for (int p = 10; p <= 12; p++) pad(p, 4'h4);
    pad(64, 4'h4);
    for (int p = 48; p <= 51; p++) pad(p, 4'h4);
    serial_mem_out = 3'b010;
    @(negedge clk_sys);
    pad(7, 4'h0);
    pad(5, 4'h8);
    pad(4, 4'h0);
    // Reprogramming the pins drops the override
    wr(7, prspc_pkg::CFG_RESET);
    pad(7, 4'h4);
    wr(5, prspc_pkg::CFG_RESET);
    wr(4, prspc_pkg::CFG_RESET);
    wr(6, prspc_pkg::CFG_RESET);
    pad(5, 4'h4);
    chk("boot_active", 4'h0, {3'h0, serial_mem_boot_active});
    // Input and output modes on an ordinary pin
    gpio_out[1] = 1'b1;
    wr(1, '{alt: 1'b0, mode: prspc_pkg::PIN_IN_PULL_UP});
    pad(1, 4'h6);
    wr(1, '{alt: 1'b0, mode: prspc_pkg::PIN_IN_PULL_DOWN});
    pad(1, 4'h5);
    wr(1, '{alt: 1'b0, mode: prspc_pkg::PIN_IN_FLOAT});
    pad(1, 4'h4);
    wr(1, '{alt: 1'b0, mode: prspc_pkg::PIN_OUT_PUSH_PULL});
    pad(1, 4'h8);
    wr(1, '{alt: 1'b0, mode: prspc_pkg::PIN_OUT_OPEN_DRAIN});
    chk("oe_n[1]", 4'h1, {3'h0, pad_ctrl[1].oe_n});
    gpio_out[1] = 1'b0;
    @(negedge clk_sys);
    pad(1, 4'h0);
    alt_out[2] = 1'b1;
    wr(2, '{alt: 1'b1, mode: prspc_pkg::PIN_OUT_PUSH_PULL});
    pad(2, 4'h8);
    // Config words have no say over the debug pins
    wr(51, '{alt: 1'b1, mode: prspc_pkg::PIN_OUT_PUSH_PULL});
    wr(49, '{alt: 1'b0, mode: prspc_pkg::PIN_IN_PULL_UP});
    wr(13, '{alt: 1'b0, mode: prspc_pkg::PIN_IN_PULL_DOWN});
    pad(51, 4'h4);
    pad(49, 4'h4);
    pad(13, 4'h0);
    debug_out = '{data_out: 1'b1, active: 1'b1};
    @(negedge clk_sys);
    pad(51, 4'h8);
    debug_out = '{data_out: 1'b0, active: 1'b1};
    @(negedge clk_sys);
    pad(51, 4'h0);
    debug_out = '{data_out: 1'b1, active: 1'b0};
    @(negedge clk_sys);
    pad(51, 4'h4);
    // Clock enable low freezes the pad flops
    clk_en = 1'b0;
    debug_out = '{data_out: 1'b1, active: 1'b1};
    @(negedge clk_sys);
    pad(51, 4'h4);
    clk_en = 1'b1;
    @(negedge clk_sys);
    pad(51, 4'h8);
    debug_out = '{data_out: 1'b1, active: 1'b0};
    @(negedge clk_sys);
    pad(51, 4'h4);
    // Returned clock follows the probe clock three edges late
    frame = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 40; k++)
    begin
      @(negedge clk_sys);
      chk("returned_clock", {3'h0, tck_hist[2]}, {3'h0, pad_ctrl[13].out});
      chk("oe_n[13]", 4'h0, {3'h0, pad_ctrl[13].oe_n});
      chk("gpio_in[51:48]", pin_h1, gpio_in[51:48]);
      chk("debug_inputs", dbg_h2, {serial_mem_data_in, test_data_in, test_mode_select, test_clock_in});
    end
    frame = 1'b0;
    // Second reset in mid-run with a non-flash boot code
    do_reset(2'b10);
    @(negedge clk_sys);
    chk("boot_active", 4'h0, {3'h0, serial_mem_boot_active});
    pad(7, 4'h4);
    pad(5, 4'h4);
    pad(4, 4'h4);
    pad(2, 4'h4);
    give_verdict();
  end
endmodule : testbench
